// [rtl/ocwc_top.sv]
// per-channel overcurrent window control for a four-channel high-side switch
`timescale 1ns/100ps
// Summary of operation
// - fault flag raised on undervoltage, any window, low, overtemp or severe short
// - turn-on is a rising on bit or input control; rewrite after fault restarts
// - fail mode restarts automatically after window two/three, low fault or undervoltage
// - fail mode latches off on overtemp, severe short or window-one fault
// - in pwm, window counters count only while channel control is on
// - window counting halts during undervoltage, charge pump failure or overtemp
// - severe short detection enabled briefly at each off-to-on transition except output turn-on by channel control in fail mode
// - normal mode toggle off then on restarts full window sequence
// - normal mode rewrite of on bit keeps window counter running
// - without input pin, on bits drive the window sequence
// - fail mode: windows follow input-pin toggles, output follows channel control
// - at full duty with ballast, window two clock divided by eight on open load
// - profile field 00 all, 01 ch3, 10 ch3 and 4, 11 none; fail forces 00
// - ballast behaviour applies only in window two, except when entered on demand
// - on-demand clear: settle low; set: low event re-enters windows two and three
// - on-demand bit cleared by overcurrent; host rewrites config then switches off
// - low-threshold select 0 high level, 1 lower level; fail forces 0
// - halved window select halves every window time; fail forces clear
// - skip window select leaves windows at once and uses low threshold
// - die temperature option reduces window one level above temperature threshold
// - turn-on option reduces window levels (not the low threshold) while output below half supply
// - faults reported to quick status and per-channel status
// - fail mode retries faulted channel after 64 ms autorestart interval
module ocwc_top
(
    input  wire logic                                clk,
    input  wire logic                                rst_n,
    input  wire logic                                fail_mode,
    input  wire logic                                mode_reset,
    input  wire logic [ocwc_pkg::CHAN_COUNT-1:0]     channel_on_bit,
    input  wire logic [ocwc_pkg::CHAN_COUNT-1:0]     on_bit_write,
    input  wire logic [ocwc_pkg::CHAN_COUNT-1:0]     internal_input_control,
    input  wire logic [ocwc_pkg::CHAN_COUNT-1:0]     input_pin_on_toggle,
    input  wire logic [ocwc_pkg::CHAN_COUNT-1:0]     channel_control_signal,
    input  wire logic [ocwc_pkg::CHAN_COUNT-1:0]     pwm_active,
    input  wire logic [ocwc_pkg::CHAN_COUNT-1:0]     full_duty,
    input  wire logic [ocwc_pkg::CHAN_COUNT-1:0]     open_load,
    input  wire logic [ocwc_pkg::CHAN_COUNT-1:0]     output_below_half,
    input  wire logic                                die_hot,
    input  wire logic                                supply_undervoltage,
    input  wire logic                                charge_pump_failure,
    input  wire logic [ocwc_pkg::CHAN_COUNT-1:0]     overtemp_shutdown,
    input  wire logic [ocwc_pkg::CHAN_COUNT-1:0]     severe_short_event,
    input  wire logic [ocwc_pkg::CHAN_COUNT-1:0]     over_level_event,
    input  wire logic [1:0]                          ballast_profile_select,
    input  wire logic [ocwc_pkg::CHAN_COUNT-1:0]     window_on_demand_set,
    input  wire logic [ocwc_pkg::CHAN_COUNT-1:0]     low_level_select,
    input  wire logic [ocwc_pkg::CHAN_COUNT-1:0]     halved_window_select,
    input  wire logic [ocwc_pkg::CHAN_COUNT-1:0]     skip_window_select,
    input  wire logic                                die_temp_level_reduce,
    input  wire logic                                turn_on_level_reduce,
    output logic      [ocwc_pkg::CHAN_COUNT-1:0]     output_enable,
    output logic      [ocwc_pkg::CHAN_COUNT-1:0]     high_current_window_one,
    output logic      [ocwc_pkg::CHAN_COUNT-1:0]     high_current_window_two,
    output logic      [ocwc_pkg::CHAN_COUNT-1:0]     high_current_window_three,
    output logic      [ocwc_pkg::CHAN_COUNT-1:0]     low_current_threshold,
    output logic      [ocwc_pkg::CHAN_COUNT-1:0]     low_threshold_lower,
    output logic      [ocwc_pkg::CHAN_COUNT-1:0]     window_one_reduced,
    output logic      [ocwc_pkg::CHAN_COUNT-1:0]     level_halved,
    output logic      [ocwc_pkg::CHAN_COUNT-1:0]     severe_short_detect,
    output logic      [ocwc_pkg::CHAN_COUNT-1:0]     window_on_demand,
    output logic      [ocwc_pkg::CHAN_COUNT-1:0]     channel_fault,
    output logic      [ocwc_pkg::CHAN_COUNT-1:0]     channel_latched,
    output logic                                     quick_fault
);

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic sync1_reg;
    logic sync2_reg;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= 1'b1;
            sync2_reg <= sync1_reg;
        end
    end

    assign rst_sync_n = sync2_reg;

    // ---------------------------------------------------------------
    // fault reporting
    // ---------------------------------------------------------------
    assign quick_fault = |channel_fault;

    // ---------------------------------------------------------------
    // per channel control
    // ---------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < ocwc_pkg::CHAN_COUNT; ch++)
        begin : g_chan
            ocwc_pkg::ocwc_state_t  state_reg;
            ocwc_pkg::ocwc_state_t  state_next;
            logic [ocwc_pkg::CNT_W-1:0] cnt_reg;
            logic [ocwc_pkg::CNT_W-1:0] cnt_next;
            logic [ocwc_pkg::CNT_W-1:0] ssc_reg;
            logic [ocwc_pkg::CNT_W-1:0] ssc_next;
            logic [2:0]             div_reg;
            logic [2:0]             div_next;
            logic                   on_prev_reg;
            logic                   in_prev_reg;
            logic                   pin_prev_reg;
            logic                   ctl_prev_reg;
            logic                   od_reg;
            logic                   od_next;
            logic                   od_entry_reg;
            logic                   od_entry_next;
            logic                   fault_reg;
            logic                   fault_next;
            logic                   turn_on;
            logic                   restart;
            logic                   tick;
            logic                   ballast_ok;
            logic                   halted;
            logic [ocwc_pkg::CNT_W-1:0] limit;
            logic                   hal_eff;
            logic                   skip_eff;
            logic                   fault_now;

            always_comb
            begin
                // fail mode forces the option bits to their defaults
                hal_eff  = halved_window_select[ch] & ~fail_mode;
                skip_eff = skip_window_select[ch] & ~fail_mode;
                case (fail_mode ? ocwc_pkg::PROFILE_RESET : ballast_profile_select)
                    ocwc_pkg::PROFILE_ALL:  ballast_ok = 1'b1;
                    ocwc_pkg::PROFILE_CH3:  ballast_ok = (ch == 2);
                    ocwc_pkg::PROFILE_CH34: ballast_ok = (ch == 2) || (ch == 3);
                    ocwc_pkg::PROFILE_NONE: ballast_ok = 1'b0;
                    default:                ballast_ok = 1'b0;
                endcase
                // turn-on source per mode
                if (fail_mode)
                    turn_on = input_pin_on_toggle[ch] & ~pin_prev_reg;
                else
                    turn_on = (channel_on_bit[ch] & ~on_prev_reg)
                            | (internal_input_control[ch] & ~in_prev_reg);
                restart = ~fail_mode & on_bit_write[ch] & channel_on_bit[ch] & fault_reg;
                halted  = supply_undervoltage | charge_pump_failure | overtemp_shutdown[ch];
                tick    = ~halted & (~pwm_active[ch] | channel_control_signal[ch]);
                if (state_reg == ocwc_pkg::OCWC_WIN2 && ballast_ok && !od_entry_reg
                    && full_duty[ch] && open_load[ch])
                    tick = tick & (div_reg == ocwc_pkg::DIV_LAST);
                case (state_reg)
                    ocwc_pkg::OCWC_WIN1: limit = ocwc_pkg::CNT_W'(ocwc_pkg::WIN1_CYCLES);
                    ocwc_pkg::OCWC_WIN2: limit = ocwc_pkg::CNT_W'(ocwc_pkg::WIN2_CYCLES);
                    ocwc_pkg::OCWC_WIN3: limit = ocwc_pkg::CNT_W'(ocwc_pkg::WIN3_CYCLES);
                    default:             limit = ocwc_pkg::CNT_W'(ocwc_pkg::RESTART_CYCLES);
                endcase
                if (hal_eff && state_reg != ocwc_pkg::OCWC_FAULT)
                    limit = limit >> 1;
                fault_now = supply_undervoltage | overtemp_shutdown[ch]
                          | severe_short_event[ch] | over_level_event[ch];
                state_next    = state_reg;
                cnt_next      = cnt_reg;
                div_next      = (state_reg == ocwc_pkg::OCWC_WIN2) ? div_reg + 3'h1 : 3'h0;
                od_next       = window_on_demand_set[ch] & ~fail_mode ? 1'b1 : od_reg;
                od_entry_next = od_entry_reg;
                fault_next    = fault_reg;
                ssc_next      = (ssc_reg != '0) ? ssc_reg - 1 : ssc_reg;
                if (turn_on || restart)
                    ssc_next = ocwc_pkg::CNT_W'(ocwc_pkg::SSC_CYCLES);
                case (state_reg)
                    ocwc_pkg::OCWC_OFF:
                    begin
                        if (turn_on || restart)
                        begin
                            state_next    = skip_eff ? ocwc_pkg::OCWC_LOW : ocwc_pkg::OCWC_WIN1;
                            cnt_next      = '0;
                            od_entry_next = 1'b0;
                            fault_next    = 1'b0;
                        end
                    end
                    ocwc_pkg::OCWC_WIN1, ocwc_pkg::OCWC_WIN2, ocwc_pkg::OCWC_WIN3, ocwc_pkg::OCWC_LOW:
                    begin
                        if (fault_now)
                        begin
                            fault_next = 1'b1;
                            cnt_next   = '0;
                            od_next    = 1'b0;
                            if (state_reg == ocwc_pkg::OCWC_LOW && od_reg && over_level_event[ch]
                                && !supply_undervoltage && !overtemp_shutdown[ch] && !severe_short_event[ch])
                            begin
                                state_next    = ocwc_pkg::OCWC_WIN2;
                                od_entry_next = 1'b1;
                                fault_next    = 1'b0;
                            end
                            else if (fail_mode && (overtemp_shutdown[ch] || severe_short_event[ch]
                                     || (state_reg == ocwc_pkg::OCWC_WIN1 && !supply_undervoltage)))
                                state_next = ocwc_pkg::OCWC_LATCHED;
                            else if (fail_mode)
                                state_next = ocwc_pkg::OCWC_FAULT;
                            else
                                state_next = ocwc_pkg::OCWC_OFF;
                        end
                        else if (!fail_mode && turn_on && ctl_prev_reg == 1'b0)
                        begin
                            state_next = skip_eff ? ocwc_pkg::OCWC_LOW : ocwc_pkg::OCWC_WIN1;
                            cnt_next   = '0;
                        end
                        else if (skip_eff && state_reg != ocwc_pkg::OCWC_LOW)
                            state_next = ocwc_pkg::OCWC_LOW;
                        else if (state_reg != ocwc_pkg::OCWC_LOW && tick)
                        begin
                            // rewrite keeps counting
                            if (cnt_reg + 1 >= limit)
                            begin
                                cnt_next   = '0;
                                state_next = ocwc_pkg::ocwc_state_t'(state_reg + 3'h1);
                            end
                            else
                                cnt_next = cnt_reg + 1;
                        end
                        if (!fail_mode && !channel_on_bit[ch] && !internal_input_control[ch]
                            && !fault_now)
                            state_next = ocwc_pkg::OCWC_OFF;
                    end
                    ocwc_pkg::OCWC_FAULT:
                    begin
                        if (!fail_mode)
                            state_next = ocwc_pkg::OCWC_OFF;
                        else if (cnt_reg + 1 >= limit)
                        begin
                            state_next = ocwc_pkg::OCWC_WIN1;
                            cnt_next   = '0;
                            fault_next = 1'b0;
                            ssc_next   = ocwc_pkg::CNT_W'(ocwc_pkg::SSC_CYCLES);
                        end
                        else
                            cnt_next = cnt_reg + 1;
                    end
                    ocwc_pkg::OCWC_LATCHED:
                    begin
                        if (mode_reset)
                        begin
                            state_next = ocwc_pkg::OCWC_OFF;
                            fault_next = 1'b0;
                        end
                    end
                    default: state_next = ocwc_pkg::OCWC_OFF;
                endcase
                if (mode_reset && state_reg != ocwc_pkg::OCWC_LATCHED)
                begin
                    state_next = ocwc_pkg::OCWC_OFF;
                    cnt_next   = '0;
                end
            end

            always_ff @(posedge clk or negedge rst_sync_n)
            begin
                if (!rst_sync_n)
                begin
                    state_reg    <= ocwc_pkg::OCWC_OFF;
                    cnt_reg      <= '0;
                    ssc_reg      <= '0;
                    div_reg      <= 3'h0;
                    on_prev_reg  <= 1'b0;
                    in_prev_reg  <= 1'b0;
                    pin_prev_reg <= 1'b0;
                    ctl_prev_reg <= 1'b0;
                    od_reg       <= 1'b0;
                    od_entry_reg <= 1'b0;
                    fault_reg    <= 1'b0;
                end
                else
                begin
                    state_reg    <= state_next;
                    cnt_reg      <= cnt_next;
                    ssc_reg      <= ssc_next;
                    div_reg      <= div_next;
                    on_prev_reg  <= channel_on_bit[ch];
                    in_prev_reg  <= internal_input_control[ch];
                    pin_prev_reg <= input_pin_on_toggle[ch];
                    ctl_prev_reg <= channel_on_bit[ch] | internal_input_control[ch];
                    od_reg       <= od_next;
                    od_entry_reg <= od_entry_next;
                    fault_reg    <= fault_next;
                end
            end

            // threshold and status outputs
            always_comb
            begin
                high_current_window_one[ch]   = (state_reg == ocwc_pkg::OCWC_WIN1);
                high_current_window_two[ch]   = (state_reg == ocwc_pkg::OCWC_WIN2);
                high_current_window_three[ch] = (state_reg == ocwc_pkg::OCWC_WIN3);
                low_current_threshold[ch]     = (state_reg == ocwc_pkg::OCWC_LOW);
                low_threshold_lower[ch]       = low_level_select[ch] & ~fail_mode;
                window_one_reduced[ch]        = die_temp_level_reduce & die_hot;
                level_halved[ch]              = turn_on_level_reduce & output_below_half[ch]
                                              & (state_reg != ocwc_pkg::OCWC_LOW);
                window_on_demand[ch]          = od_reg;
                channel_fault[ch]             = fault_reg;
                channel_latched[ch]           = (state_reg == ocwc_pkg::OCWC_LATCHED);
                output_enable[ch]             = (state_reg inside {ocwc_pkg::OCWC_WIN1, ocwc_pkg::OCWC_WIN2,
                                                 ocwc_pkg::OCWC_WIN3, ocwc_pkg::OCWC_LOW})
                                              & (~fail_mode | channel_control_signal[ch]);
                severe_short_detect[ch]       = (ssc_reg != '0) & output_enable[ch];
            end
        end
    endgenerate

endmodule : ocwc_top

// [rtl/ocwc_pkg.sv]
// constants and types for the overcurrent window control block
package ocwc_pkg;
    localparam int unsigned CHAN_COUNT      = 4;
    localparam int unsigned CLK_HZ          = 25000000;
    // window times in microseconds, as printed (typical)
    localparam int unsigned WIN1_TIME_US    = 2000;
    localparam int unsigned WIN2_TIME_US    = 8000;
    localparam int unsigned WIN3_TIME_US    = 64000;
    localparam int unsigned RESTART_TIME_US = 64000;
    // cycle counts derived from the clock rate
    localparam int unsigned WIN1_CYCLES     = WIN1_TIME_US * (CLK_HZ / 1000000);
    localparam int unsigned WIN2_CYCLES     = WIN2_TIME_US * (CLK_HZ / 1000000);
    localparam int unsigned WIN3_CYCLES     = WIN3_TIME_US * (CLK_HZ / 1000000);
    localparam int unsigned RESTART_CYCLES  = RESTART_TIME_US * (CLK_HZ / 1000000);
    localparam int unsigned CNT_W           = 32;
    localparam int unsigned BALLAST_DIV     = 8;
    localparam logic [2:0]  DIV_LAST        = 3'h7;
    localparam int unsigned SSC_TIME_US     = 50;
    localparam int unsigned SSC_CYCLES      = SSC_TIME_US * (CLK_HZ / 1000000);
    localparam logic [1:0]  PROFILE_ALL     = 2'h0;
    localparam logic [1:0]  PROFILE_CH3     = 2'h1;
    localparam logic [1:0]  PROFILE_CH34    = 2'h2;
    localparam logic [1:0]  PROFILE_NONE    = 2'h3;
    localparam logic [1:0]  PROFILE_RESET   = 2'h0;

    typedef enum logic [2:0]
    {
        OCWC_OFF     = 3'h0,
        OCWC_WIN1    = 3'h1,
        OCWC_WIN2    = 3'h2,
        OCWC_WIN3    = 3'h3,
        OCWC_LOW     = 3'h4,
        OCWC_FAULT   = 3'h5,
        OCWC_LATCHED = 3'h6
    } ocwc_state_t;
endpackage : ocwc_pkg

// [testbench/ocwc_checker.sv]
// assertion checker for the overcurrent window control top
`timescale 1ns/100ps
module ocwc_checker
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       fail_mode,
    input wire logic       mode_reset,
    input wire logic [3:0] channel_on_bit,
    input wire logic [3:0] skip_window_select,
    input wire logic [3:0] low_level_select,
    input wire logic [3:0] over_level_event,
    input wire logic [3:0] output_enable,
    input wire logic [3:0] high_current_window_one,
    input wire logic [3:0] high_current_window_two,
    input wire logic [3:0] high_current_window_three,
    input wire logic [3:0] low_current_threshold,
    input wire logic [3:0] low_threshold_lower,
    input wire logic [3:0] severe_short_detect,
    input wire logic [3:0] channel_fault,
    input wire logic [3:0] channel_latched,
    input wire logic       quick_fault
);
    // ----------------------------------------
    // channel properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire [3:0] in_win = high_current_window_one | high_current_window_two | high_current_window_three;
    a_quick_or: assert property (quick_fault == |channel_fault) else $error("quick fault mismatch");
    a_fault_off: assert property ((channel_fault & output_enable) == 4'h0) else $error("on while faulted");
    a_one_level: assert property ($onehot0({in_win[0], low_current_threshold[0]})) else $error("two levels");
    a_two_after: assert property ($rose(high_current_window_two[0]) |->
        $past(high_current_window_one[0]) || $past(low_current_threshold[0])) else $error("bad window two entry");
    a_three_after: assert property ($rose(high_current_window_three[0]) |->
        $past(high_current_window_two[0])) else $error("bad window three entry");
    a_skip_leaves: assert property (!fail_mode && skip_window_select[0] && in_win[0] |-> ##[1:2]
        !in_win[0]) else $error("window kept after skip");
    a_low_select: assert property (low_threshold_lower == (fail_mode ? 4'h0 : low_level_select))
        else $error("low threshold select wrong");
    a_latch_holds: assert property (channel_latched[2] && !mode_reset |=>
        channel_latched[2] && !output_enable[2]) else $error("latch not held");
    a_turn_on: assert property (!fail_mode && !mode_reset && $rose(channel_on_bit[0]) && !output_enable[0] &&
        !skip_window_select[0] && !over_level_event[0] |-> ##[1:2] high_current_window_one[0])
        else $error("no window one after turn on");
    a_short_on_only: assert property ((severe_short_detect & ~output_enable) == 4'h0)
        else $error("short detect while off");
    c_latch: cover property ($rose(channel_latched[2]));
    c_win_two: cover property ($rose(high_current_window_two[0]));
    c_fault: cover property ($rose(quick_fault));
endmodule : ocwc_checker

bind ocwc_top ocwc_checker chk
(
    .clk(clk), .rst_n(rst_n), .fail_mode(fail_mode), .mode_reset(mode_reset), .channel_on_bit(channel_on_bit),
    .skip_window_select(skip_window_select), .low_level_select(low_level_select),
    .over_level_event(over_level_event), .output_enable(output_enable),
    .high_current_window_one(high_current_window_one), .high_current_window_two(high_current_window_two),
    .high_current_window_three(high_current_window_three), .low_current_threshold(low_current_threshold),
    .low_threshold_lower(low_threshold_lower), .severe_short_detect(severe_short_detect),
    .channel_fault(channel_fault), .channel_latched(channel_latched), .quick_fault(quick_fault)
);

// [testbench/ocwc_host_model.sv]
// host model that writes the channel on bits
`timescale 1ns/100ps
module ocwc_host_model
(
    input  wire logic       clk,
    output logic      [3:0] channel_on_bit,
    output logic      [3:0] on_bit_write
);
    // ----------------------------------------
    // on bit writes
    // ----------------------------------------
    initial
    begin
        channel_on_bit = 4'h0;
        on_bit_write = 4'h0;
    end
    task automatic write_on(input logic [3:0] bits, input logic [3:0] mask);
        @(negedge clk);
        channel_on_bit = (channel_on_bit & ~mask) | (bits & mask);
        on_bit_write = mask;
        @(negedge clk);
        on_bit_write = 4'h0;
    endtask : write_on
endmodule : ocwc_host_model

// [testbench/test_overcurrent_window_control.sv]
// self-checking bench for the overcurrent window control block
`timescale 1ns/100ps
module test_overcurrent_window_control;
    // ----------------------------------------
    // stimulus, checks and run control
    // ----------------------------------------
    logic       clk, rst_n, fail_mode, mode_reset, die_hot, supply_undervoltage, charge_pump_failure, quick;
    logic       die_temp_level_reduce, turn_on_level_reduce;
    logic [1:0] ballast_profile_select;
    logic [3:0] internal_input_control, input_pin_on_toggle, channel_control_signal, pwm_active, full_duty;
    logic [3:0] open_load, output_below_half, overtemp_shutdown, severe_short_event, over_level_event;
    logic [3:0] window_on_demand_set, low_level_select, halved_window_select, skip_window_select;
    logic [3:0] on_bits, on_writes, oe, win1, win2, low_thr, low_lower, ssd, fault, latched;
    int         fails = 0;
    int         compares = 0;
    // rows: fail mode, low select, expected lower-threshold outputs
    localparam logic [8:0] ROWS [4] = '{9'h0AA, 9'h1F0, 9'h055, 9'h150};

    ocwc_top uut
    (
        .clk(clk), .rst_n(rst_n), .fail_mode(fail_mode), .mode_reset(mode_reset), .channel_on_bit(on_bits),
        .on_bit_write(on_writes), .internal_input_control(internal_input_control),
        .input_pin_on_toggle(input_pin_on_toggle), .channel_control_signal(channel_control_signal),
        .pwm_active(pwm_active), .full_duty(full_duty), .open_load(open_load), .die_hot(die_hot),
        .output_below_half(output_below_half), .supply_undervoltage(supply_undervoltage),
        .charge_pump_failure(charge_pump_failure), .overtemp_shutdown(overtemp_shutdown),
        .severe_short_event(severe_short_event), .over_level_event(over_level_event),
        .ballast_profile_select(ballast_profile_select), .window_on_demand_set(window_on_demand_set),
        .low_level_select(low_level_select), .halved_window_select(halved_window_select),
        .skip_window_select(skip_window_select), .die_temp_level_reduce(die_temp_level_reduce),
        .turn_on_level_reduce(turn_on_level_reduce), .output_enable(oe), .high_current_window_one(win1),
        .high_current_window_two(win2), .high_current_window_three(), .low_current_threshold(low_thr),
        .low_threshold_lower(low_lower), .window_one_reduced(), .level_halved(), .severe_short_detect(ssd),
        .window_on_demand(), .channel_fault(fault), .channel_latched(latched), .quick_fault(quick)
    );
    ocwc_host_model host (.clk(clk), .channel_on_bit(on_bits), .on_bit_write(on_writes));

    always #20 clk = ~clk;

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
        compares++;
        fails += int'(got !== exp);
        if (got !== exp)
            $display("BAD %s expected %h seen %h", what, exp, got);
    endtask : check
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    initial
    begin
        #(60000 * 40);
        fails++;
        conclude();
    end

    initial
    begin
        {clk, rst_n, fail_mode, mode_reset, die_hot, supply_undervoltage, charge_pump_failure, die_temp_level_reduce,
         turn_on_level_reduce, ballast_profile_select, internal_input_control, input_pin_on_toggle,
         channel_control_signal, pwm_active, full_duty, open_load, output_below_half, overtemp_shutdown,
         severe_short_event, over_level_event, window_on_demand_set, low_level_select, halved_window_select,
         skip_window_select} = '0;
        cyc(6);
        rst_n = 1'h1;
        cyc(4);
        foreach (ROWS[i])
        begin
            {fail_mode, low_level_select} = ROWS[i][8:4];
            cyc(1);
            check("low threshold select", ROWS[i][3:0], low_lower);
        end
        fail_mode = 1'h0;
        $display("test rows done");
        halved_window_select = 4'h2;
        host.write_on(4'h3, 4'h3);
        cyc(3);
        check("turn on window one", 4'h3, win1 & 4'h3);
        check("short detect at turn on", 4'h3, ssd & oe & 4'h3);
        cyc(ocwc_pkg::SSC_CYCLES + 50);
        check("short detect ended", 4'h0, ssd);
        cyc(ocwc_pkg::WIN1_CYCLES / 2 - 1320);
        check("halved window one", 4'h3, win1 & 4'h3);
        cyc(30);
        check("halved window two", 4'h2, win2 & 4'h3);
        cyc(ocwc_pkg::WIN1_CYCLES / 2 - 30);
        check("full window one", 4'h1, win1 & 4'h1);
        cyc(30);
        check("window two", 4'h1, win2 & 4'h1);
        over_level_event = 4'h1;
        cyc(1);
        check("fault flag", 4'h1, fault);
        check("off after fault", 4'h0, oe & 4'h1);
        check("quick fault", 4'h1, {3'h0, quick});
        over_level_event = 4'h0;
        host.write_on(4'h3, 4'h1);
        cyc(3);
        check("restart window one", 4'h1, win1 & 4'h1);
        check("short detect at restart", 4'h1, ssd & 4'h1);
        skip_window_select = 4'h1;
        cyc(3);
        check("skip to low level", 4'h1, low_thr & ~win1 & 4'h1);
        skip_window_select = 4'h0;
        $display("test normal windows done");
        host.write_on(4'h0, 4'hF);
        {fail_mode, mode_reset, channel_control_signal} = 6'h34;
        cyc(2);
        mode_reset = 1'h0;
        input_pin_on_toggle = 4'h4;
        cyc(3);
        check("fail mode window one", 4'h4, win1 & oe & 4'h4);
        cyc(ocwc_pkg::SSC_CYCLES + 50);
        over_level_event = 4'h4;
        cyc(3);
        over_level_event = 4'h0;
        check("window one latch", 4'h4, latched & ~oe & 4'h4);
        mode_reset = 1'h1;
        cyc(2);
        mode_reset = 1'h0;
        cyc(2);
        check("latch cleared", 4'h0, latched);
        $display("test fail mode done");
        conclude();
    end
endmodule : test_overcurrent_window_control
